// ===== verilog/hyp_syndrome_pkg.sv
package hyp_syndrome_pkg;

  // Syndrome register layout
  localparam int unsigned SYN_W          = 32;
  localparam int unsigned CLASS_HI       = 31;
  localparam int unsigned CLASS_LO       = 26;
  localparam int unsigned LEN_BIT        = 25;
  localparam int unsigned ISS_W          = 25;
  localparam int unsigned PRED_VALID_BIT = 24;
  localparam int unsigned PRED_HI        = 23;
  localparam int unsigned PRED_LO        = 20;
  localparam int unsigned WAIT_SEL_BIT   = 0;

  // Register offsets on the plain register port
  localparam logic [3:0] OFF_SYNDROME = 4'h0;
  localparam logic [3:0] OFF_CONTROL  = 4'h4;
  localparam logic [3:0] OFF_STATUS   = 4'h8;

  // Control and status fields, with reset values
  localparam int unsigned CTRL_CAPTURE_EN_BIT = 0;
  localparam logic        CTRL_CAPTURE_EN_RST = 1'b1;
  localparam int unsigned STAT_VALID_BIT      = 0;
  localparam int unsigned STAT_COUNT_LO       = 8;
  localparam int unsigned COUNT_W             = 8;
  localparam logic [31:0] SYNDROME_RST        = 32'h0000_0000;

  // Exception class codes
  localparam logic [5:0] EC_UNKNOWN     = 6'h00;
  localparam logic [5:0] EC_WAIT        = 6'h01;
  localparam logic [5:0] EC_CP15_REG    = 6'h03;
  localparam logic [5:0] EC_CP15_PAIR   = 6'h04;
  localparam logic [5:0] EC_CP14_REG    = 6'h05;
  localparam logic [5:0] EC_CP_LDST     = 6'h06;
  localparam logic [5:0] EC_FP_TRAP     = 6'h07;
  localparam logic [5:0] EC_FP_ID_READ  = 6'h08;
  localparam logic [5:0] EC_CP14_PAIR   = 6'h0C;
  localparam logic [5:0] EC_ILLEGAL_RET = 6'h0E;
  localparam logic [5:0] EC_SUPV_CALL   = 6'h11;
  localparam logic [5:0] EC_HYP_CALL    = 6'h12;
  localparam logic [5:0] EC_IABORT_LOW  = 6'h20;
  localparam logic [5:0] EC_IABORT_SAME = 6'h21;
  localparam logic [5:0] EC_PC_ALIGN    = 6'h22;
  localparam logic [5:0] EC_DABORT_LOW  = 6'h24;
  localparam logic [5:0] EC_DABORT_SAME = 6'h25;

  // Coprocessor field values and the unconditional predicate code
  localparam logic [3:0] COPROC_15   = 4'hF;
  localparam logic [3:0] COPROC_14   = 4'hE;
  localparam logic [3:0] PRED_ALWAYS = 4'hE;

  // Causes reported by the exception detection logic
  typedef enum logic [3:0] {
    CAUSE_UNDEF      = 4'h0,
    CAUSE_WAIT       = 4'h1,
    CAUSE_CP_REG     = 4'h2,
    CAUSE_CP_PAIR    = 4'h3,
    CAUSE_CP_LDST    = 4'h4,
    CAUSE_FP_TRAP    = 4'h5,
    CAUSE_FP_ID_READ = 4'h6,
    CAUSE_ILLEGAL    = 4'h7,
    CAUSE_SUPV_CALL  = 4'h8,
    CAUSE_HYP_CALL   = 4'h9,
    CAUSE_IABORT     = 4'hA,
    CAUSE_PC_ALIGN   = 4'hB,
    CAUSE_DABORT     = 4'hC
  } exc_cause_t;

endpackage : hyp_syndrome_pkg

// ===== verilog/hyp_exception_syndrome_capture.sv
`timescale 1ns/1ns

module hyp_exception_syndrome_capture
  import hyp_syndrome_pkg::*;
#(
  parameter bit FP_IMPLEMENTED = 1'b1  // Vector/FP unit present
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // Exception entry report from the core
  input  wire logic                         exc_valid,
  input  wire hyp_syndrome_pkg::exc_cause_t exc_cause,
  input  wire logic                         exc_unpredictable,
  input  wire logic                         exc_is_32bit,
  input  wire logic                         exc_fixed_width,
  input  wire logic                         exc_conditional,
  input  wire logic                         exc_pred_pass,
  input  wire logic [3:0]                   exc_predicate_code,
  input  wire logic                         exc_from_lower,
  input  wire logic [3:0]                   exc_coproc,
  input  wire logic                         exc_is_read,
  input  wire logic                         exc_wait_is_event,
  input  wire logic                         exc_iss_valid,
  input  wire logic [24:0]                  exc_iss_detail,
  input  wire logic                         hyp_call_disable,
  // Plain register port
  input  wire logic [3:0]                   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  // Direct view of the syndrome
  output logic      [31:0]                  hyp_exception_syndrome,
  output logic                              capture_taken
);

  import hyp_syndrome_pkg::*;

  // Captured syndrome register
  logic [31:0]        syn_q;
  logic [31:0]        syn_d;
  // Control: capture enable
  logic               cap_en_q;
  logic               cap_en_d;
  // Status: sticky valid flag and capture counter
  logic               stat_valid_q;
  logic               stat_valid_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  // Read data, one cycle after the strobe
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;

  // Encoder outputs
  logic               take;        // Exception accepted this cycle
  logic [5:0]         enc_class;
  logic               enc_len;
  logic [24:0]        enc_iss;
  logic               pred_valid;  // predicate_valid field value
  logic [3:0]         pred_code;   // predicate_code field value
  logic               unknown;     // Fall back to the unknown class

  // Predicate fields shared by wait and coprocessor encodings
  always_comb begin
    // Fixed-width encodings always give a valid predicate
    pred_valid = exc_fixed_width;
    // Unconditional fixed-width instructions report the always code
    if (!exc_fixed_width) begin
      pred_code = 4'h0;
    end else if (exc_conditional) begin
      pred_code = exc_predicate_code;
    end else begin
      pred_code = PRED_ALWAYS;
    end
  end

  // Accept the report; a failed conditional wait is no exception at all
  always_comb begin
    take = exc_valid && cap_en_q;
    if (exc_cause == CAUSE_WAIT && exc_conditional && !exc_pred_pass) begin
      take = 1'b0;
    end
  end

  // Class, length and specific syndrome encoder
  always_comb begin
    enc_class = EC_UNKNOWN;
    enc_len   = exc_is_32bit;
    enc_iss   = exc_iss_detail;
    unknown   = 1'b0;
    case (exc_cause)
      CAUSE_WAIT: begin
        enc_class = EC_WAIT;
        enc_iss   = '0;
        enc_iss[PRED_VALID_BIT]      = pred_valid;
        enc_iss[PRED_HI:PRED_LO]     = pred_code;
        enc_iss[WAIT_SEL_BIT]        = exc_wait_is_event;
      end
      CAUSE_CP_REG: begin
        // Only the two system coprocessor spaces have their own classes
        if (exc_coproc == COPROC_15) begin
          enc_class = EC_CP15_REG;
        end else if (exc_coproc == COPROC_14) begin
          enc_class = EC_CP14_REG;
        end else begin
          unknown = 1'b1;
        end
        enc_iss[PRED_VALID_BIT]  = pred_valid;
        enc_iss[PRED_HI:PRED_LO] = pred_code;
      end
      CAUSE_CP_PAIR: begin
        // The 14 space only traps the read direction
        if (exc_coproc == COPROC_15) begin
          enc_class = EC_CP15_PAIR;
        end else if (exc_coproc == COPROC_14 && exc_is_read) begin
          enc_class = EC_CP14_PAIR;
        end else begin
          unknown = 1'b1;
        end
        enc_iss[PRED_VALID_BIT]  = pred_valid;
        enc_iss[PRED_HI:PRED_LO] = pred_code;
      end
      CAUSE_CP_LDST: begin
        enc_class = EC_CP_LDST;
      end
      CAUSE_FP_TRAP: begin
        // Missing FP hardware must look like an unallocated encoding
        if (FP_IMPLEMENTED) begin
          enc_class = EC_FP_TRAP;
        end else begin
          unknown = 1'b1;
        end
      end
      CAUSE_FP_ID_READ: begin
        if (FP_IMPLEMENTED) begin
          enc_class = EC_FP_ID_READ;
        end else begin
          unknown = 1'b1;
        end
        enc_iss[PRED_VALID_BIT]  = pred_valid;
        enc_iss[PRED_HI:PRED_LO] = pred_code;
      end
      CAUSE_ILLEGAL: begin
        enc_class = EC_ILLEGAL_RET;
        enc_len   = 1'b1;
      end
      CAUSE_SUPV_CALL: begin
        enc_class = EC_SUPV_CALL;
      end
      CAUSE_HYP_CALL: begin
        // A disabled hypervisor call is an undefined instruction
        if (hyp_call_disable) begin
          unknown = 1'b1;
        end else begin
          enc_class = EC_HYP_CALL;
        end
      end
      CAUSE_IABORT: begin
        enc_class = exc_from_lower ? EC_IABORT_LOW : EC_IABORT_SAME;
        enc_len   = 1'b1;
      end
      CAUSE_PC_ALIGN: begin
        // Length bit is not meaningful here; it is driven one
        enc_class = EC_PC_ALIGN;
        enc_len   = 1'b1;
      end
      CAUSE_DABORT: begin
        enc_class = exc_from_lower ? EC_DABORT_LOW : EC_DABORT_SAME;
        if (!exc_iss_valid) begin
          enc_len = 1'b1;
        end
      end
      CAUSE_UNDEF: begin
        unknown = 1'b1;
      end
      default: begin
        // Any cause without its own class falls back to unknown
        unknown = 1'b1;
      end
    endcase
    // The unknown syndrome can arise from any level, so it leaks nothing
    if (exc_unpredictable) begin
      unknown = 1'b1;
    end
    if (unknown) begin
      enc_class = EC_UNKNOWN;
      enc_len   = 1'b1;
      enc_iss   = '0;
    end
  end

  // Register next values: capture beats a software write in the same cycle
  always_comb begin
    syn_d        = syn_q;
    cap_en_d     = cap_en_q;
    stat_valid_d = stat_valid_q;
    count_d      = count_q;
    rdata_d      = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        OFF_SYNDROME: begin
          // Reserved class values are stored as written
          syn_d = reg_wdata;
        end
        OFF_CONTROL: begin
          cap_en_d = reg_wdata[CTRL_CAPTURE_EN_BIT];
        end
        OFF_STATUS: begin
          // Write one to clear the valid flag
          if (reg_wdata[STAT_VALID_BIT]) begin
            stat_valid_d = 1'b0;
          end
        end
        default: begin
          // Unmapped writes are ignored
        end
      endcase
    end
    if (take) begin
      // One word assignment keeps the fields coherent
      syn_d        = {enc_class, enc_len, enc_iss};
      stat_valid_d = 1'b1;
      count_d      = count_q + COUNT_W'(1);
    end
    if (reg_rd) begin
      case (reg_addr)
        OFF_SYNDROME: begin
          rdata_d = syn_q;
        end
        OFF_CONTROL: begin
          rdata_d[CTRL_CAPTURE_EN_BIT] = cap_en_q;
        end
        OFF_STATUS: begin
          rdata_d[STAT_VALID_BIT]                      = stat_valid_q;
          rdata_d[STAT_COUNT_LO+COUNT_W-1:STAT_COUNT_LO] = count_q;
        end
        default: begin
          // Unmapped reads return zero
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syn_q        <= SYNDROME_RST;
      cap_en_q     <= CTRL_CAPTURE_EN_RST;
      stat_valid_q <= 1'b0;
      count_q      <= '0;
      rdata_q      <= 32'h0000_0000;
    end else begin
      syn_q        <= syn_d;
      cap_en_q     <= cap_en_d;
      stat_valid_q <= stat_valid_d;
      count_q      <= count_d;
      rdata_q      <= rdata_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign hyp_exception_syndrome = syn_q;
  assign capture_taken          = take;

  // Checks on the captured syndrome
  property p_entry_class;
    @(posedge ref_clk) disable iff (rst)
      take |=> (syn_q[CLASS_HI:CLASS_LO] == $past(enc_class));
  endproperty
  a_entry_class: assert property (p_entry_class)
    else $error("class not captured at exception entry");

  property p_unknown_zero;
    @(posedge ref_clk) disable iff (rst)
      (take && exc_cause == CAUSE_UNDEF)
        |=> (syn_q == {EC_UNKNOWN, 1'b1, 25'h0000000});
  endproperty
  a_unknown_zero: assert property (p_unknown_zero)
    else $error("unknown class syndrome not all zero with length one");

  property p_wait_fail_ignored;
    @(posedge ref_clk) disable iff (rst)
      (exc_valid && exc_cause == CAUSE_WAIT && exc_conditional && !exc_pred_pass
       && !(reg_wr && reg_addr == OFF_SYNDROME))
        |=> $stable(syn_q);
  endproperty
  a_wait_fail_ignored: assert property (p_wait_fail_ignored)
    else $error("failed conditional wait changed the syndrome");

  property p_cp_reg_class;
    @(posedge ref_clk) disable iff (rst)
      (take && !exc_unpredictable && exc_cause == CAUSE_CP_REG)
        |=> (syn_q[CLASS_HI:CLASS_LO] ==
             (($past(exc_coproc) == COPROC_15) ? EC_CP15_REG :
              ($past(exc_coproc) == COPROC_14) ? EC_CP14_REG : EC_UNKNOWN));
  endproperty
  a_cp_reg_class: assert property (p_cp_reg_class)
    else $error("single coprocessor transfer class wrong");

  property p_pair_class;
    @(posedge ref_clk) disable iff (rst)
      (take && !exc_unpredictable && exc_cause == CAUSE_CP_PAIR
       && exc_coproc == COPROC_14)
        |=> (syn_q[CLASS_HI:CLASS_LO] == ($past(exc_is_read) ? EC_CP14_PAIR : EC_UNKNOWN));
  endproperty
  a_pair_class: assert property (p_pair_class)
    else $error("pair transfer class wrong");

  property p_hyp_call;
    @(posedge ref_clk) disable iff (rst)
      (take && !exc_unpredictable && exc_cause == CAUSE_HYP_CALL)
        |=> (syn_q[CLASS_HI:CLASS_LO] == ($past(hyp_call_disable) ? EC_UNKNOWN : EC_HYP_CALL));
  endproperty
  a_hyp_call: assert property (p_hyp_call)
    else $error("hypervisor call class wrong");

  property p_abort_level;
    @(posedge ref_clk) disable iff (rst)
      (take && !exc_unpredictable && exc_cause == CAUSE_DABORT && exc_from_lower)
        |=> (syn_q[CLASS_HI:CLASS_LO] == EC_DABORT_LOW);
  endproperty
  a_abort_level: assert property (p_abort_level)
    else $error("lower-level data abort class wrong");

  property p_len_forced;
    @(posedge ref_clk) disable iff (rst)
      (take && (exc_cause == CAUSE_IABORT || exc_cause == CAUSE_ILLEGAL))
        |=> syn_q[LEN_BIT];
  endproperty
  a_len_forced: assert property (p_len_forced)
    else $error("length bit not one for fetch abort or illegal return");

  property p_len_value;
    @(posedge ref_clk) disable iff (rst)
      (take && !exc_unpredictable && exc_cause == CAUSE_SUPV_CALL)
        |=> (syn_q[LEN_BIT] == $past(exc_is_32bit));
  endproperty
  a_len_value: assert property (p_len_value)
    else $error("length bit does not follow instruction size");

  property p_wait_fields;
    @(posedge ref_clk) disable iff (rst)
      (take && !exc_unpredictable && exc_cause == CAUSE_WAIT && exc_fixed_width)
        |=> (syn_q[PRED_VALID_BIT] && syn_q[WAIT_SEL_BIT] == $past(exc_wait_is_event)
             && syn_q[PRED_HI:PRED_LO] ==
                ($past(exc_conditional) ? $past(exc_predicate_code) : PRED_ALWAYS));
  endproperty
  a_wait_fields: assert property (p_wait_fields)
    else $error("wait trap predicate or select field wrong");

  property p_unpred_leak;
    @(posedge ref_clk) disable iff (rst)
      (take && exc_unpredictable) |=> (syn_q[CLASS_HI:CLASS_LO] == EC_UNKNOWN);
  endproperty
  a_unpred_leak: assert property (p_unpred_leak)
    else $error("unpredictable case produced a privileged syndrome");

  property p_capture_beats_write;
    @(posedge ref_clk) disable iff (rst)
      (take && reg_wr && reg_addr == OFF_SYNDROME)
        |=> (syn_q == $past({enc_class, enc_len, enc_iss}));
  endproperty
  a_capture_beats_write: assert property (p_capture_beats_write)
    else $error("software write split a captured syndrome");

  c_wait_trap:  cover property (@(posedge ref_clk) disable iff (rst)
                                take && exc_cause == CAUSE_WAIT);
  c_data_abort: cover property (@(posedge ref_clk) disable iff (rst)
                                take && exc_cause == CAUSE_DABORT);
  c_sw_write:   cover property (@(posedge ref_clk) disable iff (rst)
                                reg_wr && reg_addr == OFF_SYNDROME ##1 reg_rd);
  c_back2back:  cover property (@(posedge ref_clk) disable iff (rst) take ##1 take);

endmodule : hyp_exception_syndrome_capture

// ===== bench/core_exc_model.sv
`timescale 1ns/1ns

// Stand-in for the core's exception entry logic, one report per call
module core_exc_model (
  input  wire logic                   ref_clk,
  output logic                        exc_valid          = 1'b0,
  output hyp_syndrome_pkg::exc_cause_t exc_cause         = hyp_syndrome_pkg::CAUSE_UNDEF,
  output logic                        exc_unpredictable  = 1'b0,
  output logic                        exc_is_32bit       = 1'b0,
  output logic                        exc_fixed_width    = 1'b0,
  output logic                        exc_conditional    = 1'b0,
  output logic                        exc_pred_pass      = 1'b0,
  output logic [3:0]                  exc_predicate_code = 4'h0,
  output logic                        exc_from_lower     = 1'b0,
  output logic [3:0]                  exc_coproc         = 4'h0,
  output logic                        exc_is_read        = 1'b0,
  output logic                        exc_wait_is_event  = 1'b0,
  output logic                        exc_iss_valid      = 1'b0,
  output logic [24:0]                 exc_iss_detail     = 25'h0155555,
  output logic                        hyp_call_disable   = 1'b0
);
  import hyp_syndrome_pkg::*;

  // Holds the report for exactly one cycle, then drops the strobe
  task automatic raise(input exc_cause_t c, input logic w32, fx, cd, ps,
                       input logic [3:0] cc, input logic lo, input logic [3:0] cp,
                       input logic rd, ev, iv, ds, up);
    @(posedge ref_clk);
    exc_valid          <= 1'b1;
    exc_cause          <= c;
    exc_is_32bit       <= w32;
    exc_fixed_width    <= fx;
    exc_conditional    <= cd;
    exc_pred_pass      <= ps;
    exc_predicate_code <= cc;
    exc_from_lower     <= lo;
    exc_coproc         <= cp;
    exc_is_read        <= rd;
    exc_wait_is_event  <= ev;
    exc_iss_valid      <= iv;
    hyp_call_disable   <= ds;
    exc_unpredictable  <= up;
    @(posedge ref_clk);
    exc_valid          <= 1'b0;
    // Detail is stale once released, so never leave the old pattern
    exc_iss_detail     <= ~exc_iss_detail;
  endtask : raise
endmodule : core_exc_model

// ===== bench/hyp_exception_syndrome_capture_test.sv
`timescale 1ns/1ns

module hyp_exception_syndrome_capture_test;
  import hyp_syndrome_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] syn;
  logic cap;
  logic exc_valid, exc_unpredictable, exc_is_32bit, exc_fixed_width, exc_conditional;
  logic exc_pred_pass, exc_from_lower, exc_is_read, exc_wait_is_event, exc_iss_valid;
  logic hyp_call_disable;
  exc_cause_t exc_cause;
  logic [3:0] exc_predicate_code, exc_coproc;
  logic [24:0] exc_iss_detail;
  int n_fail = 0;
  int cmp_count = 0;
  int n_cap = 0;
  int cyc = 0;

  // 25 MHz core clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  core_exc_model core (.*);

  hyp_exception_syndrome_capture DUT (.ref_clk(ref_clk), .rst(rst), .exc_valid(exc_valid),
    .exc_cause(exc_cause), .exc_unpredictable(exc_unpredictable),
    .exc_is_32bit(exc_is_32bit), .exc_fixed_width(exc_fixed_width),
    .exc_conditional(exc_conditional), .exc_pred_pass(exc_pred_pass),
    .exc_predicate_code(exc_predicate_code), .exc_from_lower(exc_from_lower),
    .exc_coproc(exc_coproc), .exc_is_read(exc_is_read),
    .exc_wait_is_event(exc_wait_is_event), .exc_iss_valid(exc_iss_valid),
    .exc_iss_detail(exc_iss_detail), .hyp_call_disable(hyp_call_disable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hyp_exception_syndrome(syn), .capture_taken(cap));

  // Accepted captures and the hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cap === 1'b1) n_cap <= n_cap + 1;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // One class-table row: class and length bit checked together
  task automatic cls(input exc_cause_t c, input logic lo, input logic [3:0] cp,
                     input logic r, iv, ds, up, input logic [6:0] exp);
    core.raise(c, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, lo, cp, r, 1'b0, iv, ds, up);
    #1 chk({25'h0, syn[31:25]}, {25'h0, exp});
  endtask : cls

  task automatic t_regs;
    rd(OFF_SYNDROME, SYNDROME_RST);
    rd(OFF_CONTROL, 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(OFF_SYNDROME, 32'hFFFF_FFFF);
    rd(OFF_SYNDROME, 32'hFFFF_FFFF);
    wr(4'hC, 32'h1234_5678);
    rd(4'hC, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_wait;
    int n0;
    core.raise(CAUSE_WAIT, 1'b1, 1'b1, 1'b0, 1'b1, 4'h5, 1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    #1 chk(syn, 32'h07E0_0001);
    core.raise(CAUSE_WAIT, 1'b0, 1'b1, 1'b1, 1'b1, 4'h3, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk(syn, 32'h0530_0000);
    n0 = n_cap;
    core.raise(CAUSE_WAIT, 1'b1, 1'b1, 1'b1, 1'b0, 4'h3, 1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    #1 chk(syn, 32'h0530_0000);
    chk(n_cap, n0);
    $display("test wait done");
  endtask : t_wait

  // Status count and clear, capture disable, and captures racing software writes
  task automatic t_status;
    rd(OFF_STATUS, 32'h0000_0201);
    chk(n_cap, 32'h0000_0002);
    wr(OFF_STATUS, 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0200);
    wr(OFF_CONTROL, 32'h0000_0000);
    core.raise(CAUSE_SUPV_CALL, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0,
               1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk(syn, 32'h0530_0000);
    rd(OFF_STATUS, 32'h0000_0200);
    wr(OFF_CONTROL, 32'h0000_0001);
    // Same-cycle software write to the syndrome loses to the capture
    fork
      core.raise(CAUSE_SUPV_CALL, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0,
                 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      wr(OFF_SYNDROME, 32'h0000_0000);
    join
    #1 chk({25'h0, syn[31:25]}, {25'h0, 6'h11, 1'b1});
    // Same-cycle clear of the valid flag loses to the capture
    fork
      core.raise(CAUSE_SUPV_CALL, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0,
                 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      wr(OFF_STATUS, 32'h0000_0001);
    join
    rd(OFF_STATUS, 32'h0000_0401);
    $display("test status done");
  endtask : t_status

  task automatic t_classes;
    core.raise(CAUSE_UNDEF, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk(syn, 32'h0200_0000);
    core.raise(CAUSE_CP_REG, 1'b1, 1'b1, 1'b1, 1'b1, 4'h3, 1'b0, 4'hF,
               1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk({20'h0, syn[31:20]}, {20'h0, 6'h03, 1'b1, 1'b1, 4'h3});
    cls(CAUSE_CP_REG, 1'b0, 4'hF, 1'b1, 1'b1, 1'b0, 1'b0, {6'h03, 1'b0});
    cls(CAUSE_CP_REG, 1'b0, 4'hE, 1'b0, 1'b1, 1'b0, 1'b0, {6'h05, 1'b0});
    cls(CAUSE_CP_PAIR, 1'b0, 4'hF, 1'b0, 1'b1, 1'b0, 1'b0, {6'h04, 1'b0});
    cls(CAUSE_CP_PAIR, 1'b0, 4'hE, 1'b1, 1'b1, 1'b0, 1'b0, {6'h0C, 1'b0});
    cls(CAUSE_CP_PAIR, 1'b0, 4'hE, 1'b0, 1'b1, 1'b0, 1'b0, {6'h00, 1'b1});
    cls(CAUSE_CP_LDST, 1'b0, 4'hE, 1'b0, 1'b1, 1'b0, 1'b0, {6'h06, 1'b0});
    cls(CAUSE_FP_TRAP, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h07, 1'b0});
    cls(CAUSE_FP_ID_READ, 1'b0, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0, {6'h08, 1'b0});
    cls(CAUSE_ILLEGAL, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h0E, 1'b1});
    cls(CAUSE_SUPV_CALL, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h11, 1'b0});
    cls(CAUSE_HYP_CALL, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h12, 1'b0});
    cls(CAUSE_HYP_CALL, 1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0, {6'h00, 1'b1});
    cls(CAUSE_SUPV_CALL, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1, {6'h00, 1'b1});
    cls(CAUSE_IABORT, 1'b1, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h20, 1'b1});
    cls(CAUSE_IABORT, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h21, 1'b1});
    cls(CAUSE_DABORT, 1'b1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, {6'h24, 1'b1});
    cls(CAUSE_DABORT, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, {6'h25, 1'b0});
    core.raise(CAUSE_PC_ALIGN, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk({26'h0, syn[31:26]}, {26'h0, 6'h22});
    $display("test classes done");
  endtask : t_classes

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_wait();
    t_status();
    t_classes();
    summarize();
  end
endmodule : hyp_exception_syndrome_capture_test
